// ===== common/ctl_regs_pkg.sv
/*
 * Shared constants and types for the memory-mapped control register bank:
 * register offsets, identity values, capability and ring sizing defaults,
 * and the packed structs that carry bus requests and answers.
 * Assumes a single clock and a 32-bit word-addressed bus with byte offsets.
 */
package ctl_regs_pkg;

    // Bus widths
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_SIGNATURE      = 12'h000;
    localparam logic [11:0] OFF_REVISION       = 12'h004;
    localparam logic [11:0] OFF_DEV_TYPE       = 12'h008;
    localparam logic [11:0] OFF_MAKER          = 12'h00C;
    localparam logic [11:0] OFF_OFFERED_WORD   = 12'h010;
    localparam logic [11:0] OFF_OFFERED_SEL    = 12'h014;
    localparam logic [11:0] OFF_ACCEPTED_WORD  = 12'h020;
    localparam logic [11:0] OFF_ACCEPTED_SEL   = 12'h024;
    localparam logic [11:0] OFF_RING_SELECT    = 12'h030;
    localparam logic [11:0] OFF_RING_LIMIT     = 12'h034;
    localparam logic [11:0] OFF_RING_SIZE      = 12'h038;
    // Device-specific configuration space starts right after the bank
    localparam logic [11:0] OFF_DEV_CONFIG     = 12'h100;

    // Fixed identity words, both values arbitrary; the tag is four ASCII
    // characters, first in byte 0
    localparam logic [31:0] SIGNATURE_VALUE    = {8'h6B, 8'h6E, 8'h61, 8'h62};
    localparam logic [31:0] REVISION_CURRENT   = 32'h0000_0003;

    // Reset values
    localparam logic [31:0] SELECT_RESET       = 32'h0000_0000;
    localparam logic [15:0] RING_SIZE_RESET    = 16'h0000;

    // Read answer for registers that cannot be read
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    // Bus request as seen by the bank
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [11:0]       addr;
        logic [31:0]       wdata;
    } bus_req_t;

    // Bus answer
    typedef struct packed {
        logic              rvalid;
        logic [31:0]       rdata;
    } bus_rsp_t;

endpackage : ctl_regs_pkg

// ===== hdl/capability_bank.sv
/*
 * Windowed capability store: a group of 32-bit words addressed by a select
 * value, one word loaded per write. Used for the accepted capability flags.
 * Assumes the caller qualifies writes and resets through rst_b.
 */
`timescale 1ns/100ps
module capability_bank
    import ctl_regs_pkg::*;
#(
    parameter int unsigned WORDS = 2
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Word load
    input  wire logic                    load,
    input  wire logic [31:0]             word_sel,
    input  wire logic [31:0]             word_data,
    // Flat view of all flags
    output logic      [WORDS*32-1:0]     flags
);

    // One flip-flop word per entry, each with its own enable
    for (genvar g = 0; g < WORDS; g++) begin : g_word
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                flags[g*32 +: 32] <= 32'h0000_0000;
            end else if (load && word_sel == 32'(g)) begin
                // Selected word takes the whole written value
                flags[g*32 +: 32] <= word_data;
            end
        end
    end

endmodule : capability_bank

// ===== hdl/ctl_regs.sv
/*
 * Memory-mapped control register bank, front portion: identity words,
 * offered and accepted capability windows, ring selection and sizing.
 * Assumes a simple synchronous bus: rd or wr held for one cycle with addr
 * and wdata; bank read data returns one cycle later with rvalid, config read data two cycles later. Accesses are
 * whole aligned words. All offsets at or above the device-specific config
 * base are handed to that space through the cfg_* ports.
 */
// Contract
// - Register values presented little-endian on bus.
// - Device config space follows control registers.
// - Offset zero returns fixed ASCII signature word.
// - Read-only interface revision number returned.
// - Read-only device type and maker codes.
// - Offered word read returns selected 32 flags.
// - Offered word select stored, steers reads.
// - Accepted word write sets selected 32 flags.
// - Accepted word select stored, steers writes.
// - Ring select chooses target of ring registers.
// - Ring indices count from zero.
// - Size limit returns max count or zero.
// - Driver-written ring size kept per ring.
`timescale 1ns/100ps
module ctl_regs
    import ctl_regs_pkg::*;
#(
    parameter logic [31:0] DEVICE_TYPE   = 32'h0000_0010,   // Arbitrary value
    parameter logic [31:0] MAKER         = 32'h0000_5A5A,   // Arbitrary value
    parameter int unsigned OFFER_WORDS   = 2,               // Offered windows
    parameter logic [OFFER_WORDS*32-1:0] OFFERED_FLAGS = '0,
    parameter int unsigned RINGS         = 4,               // Rings present
    parameter int unsigned RING_IDX_W    = 2,
    parameter logic [15:0] RING_MAX      = 16'h0100         // Largest count
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // Register bus
    input  wire logic                         bus_rd,
    input  wire logic                         bus_wr,
    input  wire logic [11:0]                  bus_addr,
    input  wire logic [31:0]                  bus_wdata,
    output logic      [31:0]                  bus_rdata,
    output logic                              bus_rvalid,
    // Device-specific configuration space
    output logic                              cfg_rd,
    output logic                              cfg_wr,
    output logic      [11:0]                  cfg_addr,
    output logic      [31:0]                  cfg_wdata,
    input  wire logic [31:0]                  cfg_rdata,
    // State toward the rest of the device
    output logic      [OFFER_WORDS*32-1:0]    accepted_flags,
    output logic      [31:0]                  ring_select,
    output logic      [15:0]                  ring_size_sel
);

    // Request bundled once so decode reads one struct
    bus_req_t                     req;
    // Stored selects
    logic     [31:0]              offered_word_select;
    logic     [31:0]              accepted_word_select;
    // Write strobes per register
    logic                         wr_offered_sel;
    logic                         wr_accepted_sel;
    logic                         wr_accepted_word;
    logic                         wr_ring_select;
    logic                         wr_ring_size;
    // Ring state
    logic     [RINGS*16-1:0]      ring_sizes;
    logic                         ring_present;
    logic     [RING_IDX_W-1:0]    ring_idx;
    // Read path
    logic     [31:0]              next_rdata;
    logic                         cfg_hit;
    logic                         cfg_pending;
    logic     [31:0]              offered_word;
    logic     [15:0]              next_ring_size;

    assign req = '{rd: bus_rd, wr: bus_wr, addr: bus_addr, wdata: bus_wdata};

    // Anything at or above the config base belongs to the device's own space
    assign cfg_hit = (req.addr >= OFF_DEV_CONFIG);

    // Write strobes; read-only offsets have no strobe, so writes there vanish
    assign wr_offered_sel   = req.wr && req.addr == OFF_OFFERED_SEL;
    assign wr_accepted_sel  = req.wr && req.addr == OFF_ACCEPTED_SEL;
    assign wr_accepted_word = req.wr && req.addr == OFF_ACCEPTED_WORD;
    assign wr_ring_select   = req.wr && req.addr == OFF_RING_SELECT;
    assign wr_ring_size     = req.wr && req.addr == OFF_RING_SIZE;

    // Offered word select
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            offered_word_select <= SELECT_RESET;
        end else if (wr_offered_sel) begin
            offered_word_select <= req.wdata;
        end
    end

    // Accepted word select
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accepted_word_select <= SELECT_RESET;
        end else if (wr_accepted_sel) begin
            accepted_word_select <= req.wdata;
        end
    end

    // Ring select; kept full width so an absent index reads limit zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ring_select <= SELECT_RESET;
        end else if (wr_ring_select) begin
            ring_select <= req.wdata;
        end
    end

    // Index zero is the first ring; values of RINGS and above are absent
    assign ring_present = (ring_select < 32'(RINGS));
    assign ring_idx     = ring_select[RING_IDX_W-1:0];

    // Accepted capability flags, windowed by the accepted select
    capability_bank #(
        .WORDS      (OFFER_WORDS)
    ) u_accepted (
        .clk        (clk),
        .rst_b      (rst_b),
        .load       (wr_accepted_word),
        .word_sel   (accepted_word_select),
        .word_data  (req.wdata),
        .flags      (accepted_flags)
    );

    // Sizes only land for rings that exist; others drop silently
    ring_size_table #(
        .RINGS      (RINGS),
        .IDX_W      (RING_IDX_W)
    ) u_sizes (
        .clk        (clk),
        .rst_b      (rst_b),
        .load       (wr_ring_size && ring_present),
        .idx        (ring_idx),
        .size_in    (req.wdata[15:0]),
        .sizes      (ring_sizes)
    );

    // Size of the selected ring, registered for the outside
    assign next_ring_size = ring_present ? ring_sizes[ring_idx*16 +: 16] : 16'h0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ring_size_sel <= RING_SIZE_RESET;
        end else begin
            ring_size_sel <= next_ring_size;
        end
    end

    // Offered window; a select past the stored words reads all zero
    always_comb begin
        offered_word = 32'h0000_0000;
        for (int i = 0; i < OFFER_WORDS; i++) begin
            if (offered_word_select == 32'(i)) begin
                offered_word = OFFERED_FLAGS[i*32 +: 32];
            end
        end
    end

    // Read mux; bus byte 0 is bits 7:0, so words go out little-endian
    always_comb begin
        case (req.addr)
            OFF_SIGNATURE:    next_rdata = SIGNATURE_VALUE;
            OFF_REVISION:     next_rdata = REVISION_CURRENT;
            OFF_DEV_TYPE:     next_rdata = DEVICE_TYPE;
            OFF_MAKER:        next_rdata = MAKER;
            OFF_OFFERED_WORD: next_rdata = offered_word;
            OFF_RING_LIMIT: begin
                // Zero tells software the ring does not exist
                next_rdata = ring_present ? {16'h0000, RING_MAX} : READ_ZERO;
            end
            // Write-only and unmapped offsets read as zero
            default:          next_rdata = READ_ZERO;
        endcase
    end

    // Config space pass-through, registered so outputs come from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rd    <= 1'b0;
            cfg_wr    <= 1'b0;
            cfg_addr  <= 12'h000;
            cfg_wdata <= 32'h0000_0000;
        end else begin
            cfg_rd    <= req.rd && cfg_hit;
            cfg_wr    <= req.wr && cfg_hit;
            cfg_addr  <= req.addr - OFF_DEV_CONFIG;
            cfg_wdata <= req.wdata;
        end
    end

    // Config reads answer one cycle after the forwarded strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_pending <= 1'b0;
        end else begin
            cfg_pending <= req.rd && cfg_hit;
        end
    end

    // Read answer: bank reads take one cycle, config reads take two
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rvalid <= 1'b0;
            bus_rdata  <= 32'h0000_0000;
        end else if (cfg_pending) begin
            bus_rvalid <= 1'b1;
            bus_rdata  <= cfg_rdata;
        end else if (req.rd && !cfg_hit) begin
            bus_rvalid <= 1'b1;
            bus_rdata  <= next_rdata;
        end else begin
            bus_rvalid <= 1'b0;
        end
    end

    // Assertions

    // Signature answers one cycle after the read
    a_signature_read: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_SIGNATURE
        |=> bus_rvalid && bus_rdata == SIGNATURE_VALUE)
        else $error("signature word wrong");

    // Leading tag character b sits in bits 7:0
    a_sig_byte_order: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_SIGNATURE
        |=> bus_rdata[7:0] == 8'h62)
        else $error("signature byte 0 wrong");

    // Revision is a fixed word
    a_revision_read: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_REVISION
        |=> bus_rdata == REVISION_CURRENT)
        else $error("revision wrong");

    // Maker code reads back the parameter
    a_ident_read: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_MAKER
        |=> bus_rdata == MAKER)
        else $error("maker code wrong");

    // Device type reads back the parameter
    a_type_read: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_DEV_TYPE
        |=> bus_rvalid && bus_rdata == DEVICE_TYPE)
        else $error("device type code wrong");

    // Offered select keeps the written value
    a_offered_sel_held: assert property (@(posedge clk) disable iff (!rst_b)
        wr_offered_sel
        |=> offered_word_select == $past(req.wdata))
        else $error("offered select not stored");

    // Select zero shows the low offered word
    a_offered_window: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_OFFERED_WORD && offered_word_select == 32'h0
        |=> bus_rdata == OFFERED_FLAGS[31:0])
        else $error("offered window wrong");

    // Highest select shows the top offered word
    a_offered_upper: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_OFFERED_WORD && offered_word_select == 32'(OFFER_WORDS - 1)
        |=> bus_rdata == OFFERED_FLAGS[OFFER_WORDS*32-1 -: 32])
        else $error("offered upper window wrong");

    // Select zero loads the low accepted word
    a_accepted_load: assert property (@(posedge clk) disable iff (!rst_b)
        wr_accepted_word && accepted_word_select == 32'h0
        |=> accepted_flags[31:0] == $past(req.wdata))
        else $error("accepted word not loaded");

    // Select one leaves the low word alone
    a_accepted_sel_one: assert property (@(posedge clk) disable iff (!rst_b)
        wr_accepted_word && accepted_word_select == 32'h1
        |=> $stable(accepted_flags[31:0]))
        else $error("accepted select steered wrong word");

    // Writing zero selects the first ring
    a_ring_zero_first: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ring_select && req.wdata == 32'h0 ##1 !wr_ring_select ##1 wr_ring_size
        |=> ##1 ring_size_sel == ring_sizes[15:0])
        else $error("ring zero not first");

    // Absent ring reports limit zero
    a_limit_absent: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_RING_LIMIT && !ring_present
        |=> bus_rdata == 32'h0)
        else $error("absent ring limit not zero");

    // Present ring reports the largest count
    a_limit_present: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_RING_LIMIT && ring_present
        |=> bus_rdata == {16'h0000, RING_MAX})
        else $error("present ring limit wrong");

    // Size write lands in the selected ring
    a_size_kept: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ring_size && ring_present
        |=> ##1 ring_size_sel == $past(req.wdata[15:0], 2))
        else $error("ring size not kept");

    // Write-only places read as zero
    a_wo_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && (req.addr == OFF_RING_SIZE || req.addr == OFF_ACCEPTED_SEL)
        |=> bus_rdata == 32'h0)
        else $error("write-only read not zero");

    // Config reads leave the bank, answer a cycle late
    a_cfg_forward: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && cfg_hit
        |=> cfg_rd ##1 bus_rvalid)
        else $error("config read not forwarded");

    // Config writes carry offset and data along
    a_cfg_write_fwd: assert property (@(posedge clk) disable iff (!rst_b)
        req.wr && cfg_hit
        |=> cfg_wr && cfg_addr + OFF_DEV_CONFIG == $past(req.addr) && cfg_wdata == $past(req.wdata))
        else $error("config write not forwarded");

    // Release of reset finds ring select and accepted flags clear
    a_reset_clear: assert property (@(posedge clk)
        $rose(rst_b)
        |-> ring_select == 32'h0 && accepted_flags == '0)
        else $error("reset state not zero");

    // Main scenarios
    c_signature:  cover property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == OFF_SIGNATURE);

    c_accept_hi:  cover property (@(posedge clk) disable iff (!rst_b)
        wr_accepted_word && accepted_word_select == 32'h1);

    c_ring_setup: cover property (@(posedge clk) disable iff (!rst_b)
        wr_ring_select ##[1:4] wr_ring_size);

    c_cfg_read:   cover property (@(posedge clk) disable iff (!rst_b)
        req.rd && cfg_hit);

endmodule : ctl_regs

// ===== hdl/ring_size_table.sv
/*
 * Per-ring size store: one element count per ring, written at the selected
 * index, read back as a flat view of every entry for the rest of the device.
 * Assumes indices beyond the ring count are filtered by the caller.
 */
`timescale 1ns/100ps
module ring_size_table
    import ctl_regs_pkg::*;
#(
    parameter int unsigned RINGS  = 4,
    parameter int unsigned IDX_W  = 2
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Write port
    input  wire logic                    load,
    input  wire logic [IDX_W-1:0]        idx,
    input  wire logic [15:0]             size_in,
    // Flat view of every ring size
    output logic      [RINGS*16-1:0]     sizes
);

    // One 16-bit entry per ring
    for (genvar g = 0; g < RINGS; g++) begin : g_ring
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                sizes[g*16 +: 16] <= RING_SIZE_RESET;
            end else if (load && idx == IDX_W'(g)) begin
                sizes[g*16 +: 16] <= size_in;
            end
        end
    end

endmodule : ring_size_table

// ===== sim/tb_mmio_device_control_registers.sv
/*
 * Self-checking bench for the control register bank: identity words,
 * capability windows, ring selection and sizing, config space hand-off.
 * Assumes the bank answers bank reads one cycle after the strobe edge.
 */
`timescale 1ns/100ps
module tb_mmio_device_control_registers
    import ctl_regs_pkg::*;
;
    // Bench settings; identity codes are arbitrary
    localparam logic [63:0] OFFER       = 64'hC3A5_0F01_8421_7E5B;
    localparam logic [15:0] RMAX        = 16'h0080;
    localparam logic [31:0] DEV_T       = 32'h0000_0031;  // Arbitrary value
    localparam logic [31:0] MAKER_V     = 32'h0000_6B6B;  // Arbitrary value
    localparam int          CYCLE_LIMIT = 20000;

    logic        clk;                 // System clock
    logic        rst_b;               // Async reset, active low
    bus_req_t    req;                 // Request toward the bank
    logic [31:0] bus_rdata;           // Read answer
    logic        bus_rvalid;          // Answer strobe
    logic        cfg_rd;              // Forwarded config read
    logic        cfg_wr;              // Forwarded config write
    logic [11:0] cfg_addr;            // Config offset
    logic [31:0] cfg_wdata;           // Config write data
    logic [31:0] cfg_rdata;           // Config answer
    logic [63:0] accepted_flags;      // Accepted flags seen
    logic [31:0] ring_select;         // Selected ring seen
    logic [15:0] ring_size_sel;       // Size of selected ring seen
    logic [31:0] seed;                // Xorshift state
    int          failures;            // Mismatch count
    int          n_compared;          // Comparison count
    int          cycles;              // Timeout counter
    int          cfg_hits;            // Config strobes seen
    logic [44:0] cfg_last;            // Last config access {wr, addr, wdata}
    // Reference model of the bank state
    logic [63:0] acc;
    logic [31:0] rsel;
    logic [15:0] sizes [4];

    ctl_regs #(.DEVICE_TYPE(DEV_T), .MAKER(MAKER_V), .OFFER_WORDS(2),
               .OFFERED_FLAGS(OFFER), .RINGS(4), .RING_IDX_W(2),
               .RING_MAX(RMAX)) u_dut (
        .clk(clk), .rst_b(rst_b),
        .bus_rd(req.rd), .bus_wr(req.wr), .bus_addr(req.addr), .bus_wdata(req.wdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .accepted_flags(accepted_flags), .ring_select(ring_select),
        .ring_size_sel(ring_size_sel)
    );

    // Config space answers only while selected, else a flipped pattern
    assign cfg_rdata = cfg_rd ? {20'hC0F1E, cfg_addr} : ~{20'hC0F1E, cfg_addr};

    // Clock, 4 ns period
    always #2 clk = ~clk;

    // Monitor config strobes away from the launching edge
    always @(negedge clk) begin
        if (cfg_rd === 1'b1 || cfg_wr === 1'b1) begin
            cfg_hits++;
            cfg_last = {cfg_wr, cfg_addr, cfg_wdata};
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            failures++;
            test_done();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Expected offered window; selects past the words read zero
    function automatic logic [31:0] offered_exp(input logic [31:0] s);
        return (s < 2) ? OFFER[s[0]*32 +: 32] : 32'h0000_0000;
    endfunction : offered_exp

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk); #1;
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk); #1;
        req.wr = 1'b0;
    endtask : bus_write

    // Read and compare data and answer latency in cycles after the take edge
    task automatic expect_read(input string name, input logic [11:0] a,
                               input logic [31:0] exp, input int exp_lat);
        int lat;
        lat = 0;
        @(posedge clk); #1;
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
        @(posedge clk); #1;
        req.rd = 1'b0;
        while (bus_rvalid !== 1'b1 && lat < 4) begin
            @(posedge clk); #1;
            lat++;
        end
        chk(name, exp, bus_rdata);
        chk({name, " latency"}, exp_lat, lat);
    endtask : expect_read

    // Let pending updates land, then compare the state outputs
    task automatic check_state();
        @(posedge clk); #1;
        chk("accepted_flags", acc, accepted_flags);
        chk("ring_select", rsel, ring_select);
        chk("ring_size_sel", (rsel < 4) ? sizes[rsel[1:0]] : 16'h0000, ring_size_sel);
    endtask : check_state

    task automatic model_reset();
        acc   = '0;
        rsel  = '0;
        sizes = '{default: 16'h0000};
    endtask : model_reset

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic [31:0] s;
        logic [11:0] id_a [4];
        logic [31:0] id_v [4];
        logic [11:0] wo_a [7];
        clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        seed = 32'h25E7;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        cfg_hits = 0;
        id_a = '{OFF_SIGNATURE, OFF_REVISION, OFF_DEV_TYPE, OFF_MAKER};
        id_v = '{SIGNATURE_VALUE, REVISION_CURRENT, DEV_T, MAKER_V};
        wo_a = '{OFF_OFFERED_SEL, OFF_ACCEPTED_WORD, OFF_ACCEPTED_SEL, OFF_RING_SELECT,
                 OFF_RING_SIZE, 12'h018, 12'h0FC};
        model_reset();
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        check_state();
        // Identity words, first tag character in the low byte
        for (int i = 0; i < 4; i++) begin
            expect_read("identity", id_a[i], id_v[i], 0);
        end
        expect_read("signature", OFF_SIGNATURE, SIGNATURE_VALUE, 0);
        chk("signature byte 0", 8'h62, bus_rdata[7:0]);
        // Offered windows, including one past the last word
        for (int i = 0; i < 3; i++) begin
            bus_write(OFF_OFFERED_SEL, i);
            expect_read("offered word", OFF_OFFERED_WORD, offered_exp(i), 0);
        end
        // Every ring index from zero, plus one absent ring
        for (int i = 0; i < 5; i++) begin
            rsel = i;
            bus_write(OFF_RING_SELECT, rsel);
            check_state();
            expect_read("ring limit", OFF_RING_LIMIT,
                        (i < 4) ? {16'h0, RMAX} : 32'h0, 0);
        end
        // Random mix of selects, loads and read-only writes
        for (int i = 0; i < 80; i++) begin
            r = rnd();
            d = rnd();
            s = {30'h0, r[9:8]};
            case (r[1:0])
                2'd0: begin // Ring select then size
                    rsel = (s == 3) ? 32'h4 : s ^ {31'h0, r[4]};
                    bus_write(OFF_RING_SELECT, rsel);
                    bus_write(OFF_RING_SIZE, d);
                    if (rsel < 4) sizes[rsel[1:0]] = d[15:0];
                end
                2'd1: begin // Accepted window load; select 2 or 3 is dropped
                    bus_write(OFF_ACCEPTED_SEL, s);
                    bus_write(OFF_ACCEPTED_WORD, d);
                    if (s < 2) acc[s[0]*32 +: 32] = d;
                end
                2'd2: begin // Offered window read
                    bus_write(OFF_OFFERED_SEL, s);
                    expect_read("offered word", OFF_OFFERED_WORD, offered_exp(s), 0);
                end
                default: begin // Writes to read-only places leave them alone
                    bus_write(OFF_REVISION, d);
                    bus_write(OFF_RING_LIMIT, d);
                    expect_read("revision", OFF_REVISION, REVISION_CURRENT, 0);
                end
            endcase
            check_state();
        end
        // Write-only and unmapped places read zero
        for (int i = 0; i < 7; i++) expect_read("write-only", wo_a[i], 32'h0, 0);
        // Config space sits right after the bank
        expect_read("config read", 12'h104, {20'hC0F1E, 12'h004}, 1);
        chk("config read addr", {1'b0, 12'h004}, cfg_last[44:32]);
        d = rnd();
        bus_write(12'h108, d);
        @(posedge clk); #1;
        chk("config write", {1'b1, 12'h008, d}, cfg_last);
        chk("config strobes", 2, cfg_hits);
        // Reset in mid-run clears selects, flags and sizes
        @(posedge clk); #1;
        rst_b = 1'b0;
        model_reset();
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        check_state();
        expect_read("offered after reset", OFF_OFFERED_WORD, OFFER[31:0], 0);
        d = rnd();
        bus_write(OFF_ACCEPTED_WORD, d);
        acc[31:0] = d;
        check_state();
        // Every ring size was cleared by the mid-run reset
        for (int i = 0; i < 4; i++) begin
            rsel = i;
            bus_write(OFF_RING_SELECT, rsel);
            check_state();
        end
        test_done();
    end
endmodule : tb_mmio_device_control_registers
